/* File: hw/asv_status.v */
// asv_status.v: bits 15 to 7 of the per-channel status word
// link, fault, speed, duplex and pause fields, each from its own source
// assumes all inputs come from logic on the core reference clock
// assumes i_mgmt_rd pulses once for each completed management read
// assumes the negotiation engine holds its results while done is high
`timescale 1ns/1ns
`include "asv_map.vh"
module asv_status (
  // core reference clock, reset, enable
  input  wire        i_sys_clk,
  input  wire        i_rstn,
  input  wire        i_ce,
  // configuration
  input  wire        i_an_enable,
  input  wire        i_phy_mode,
  // negotiation results
  input  wire        i_an_complete,
  input  wire        i_phy_link,
  input  wire [1:0]  i_speed,
  input  wire        i_full_duplex,
  input  wire [15:0] i_lp_base,
  // remote fault detection
  input  wire        i_rf_detect,
  input  wire [1:0]  i_rf_code,
  // management read strobe
  input  wire        i_mgmt_rd,
  input  wire [4:0]  i_mgmt_reg,
  // status outputs
  output reg  [15:7] o_status
);

  ////////////////////////////////////////////////////////////////////////
  // field widths
  localparam SPEED_W = 2;
  localparam FAULT_W = 2;
  localparam PAUSE_W = 2;
  localparam ADDR_W  = 5;
  localparam LP_W    = 16;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // a read of the status register, or a reset, is the only thing that clears the flag
  function is_status_read;
    input              rd;
    input [ADDR_W-1:0] addr;
    begin
      is_status_read = rd && (addr == `ASV_REG_STATUS);
    end
  endfunction

  // fault reports count only while AN is enabled
  function fault_taken;
    input detect;
    input an_en;
    begin
      fault_taken = detect && an_en;
    end
  endfunction

  // negotiated fields mean something only once AN is on and done
  function neg_valid;
    input an_en;
    input an_done;
    begin
      neg_valid = an_en && an_done;
    end
  endfunction

  // fault encoding reads zero in phy mode or with AN off
  function [FAULT_W-1:0] fault_view;
    input               phy;
    input               an_en;
    input [FAULT_W-1:0] code;
    begin
      if (phy || !an_en) begin
        fault_view = `ASV_RF_NONE;
      end else begin
        fault_view = code;
      end
    end
  endfunction

  // the reserved speed code is passed on as received; the host decides
  function [SPEED_W-1:0] speed_view;
    input               done;
    input [SPEED_W-1:0] speed;
    begin
      if (done) begin
        speed_view = speed;
      end else begin
        speed_view = `ASV_SPEED_10;
      end
    end
  endfunction

  // partner pause bits keep their order: bit 8 high, bit 7 low
  function [PAUSE_W-1:0] pause_view;
    input            done;
    input [LP_W-1:0] lp;
    begin
      if (done) begin
        pause_view = {lp[`ASV_PAUSE_HI], lp[`ASV_PAUSE_LO]};
      end else begin
        pause_view = 2'h0;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // declarations

  // fault path
  wire               rd_status;
  wire               rf_event;
  wire               rf_flag;
  reg  [FAULT_W-1:0] rf_code_reg;
  reg  [FAULT_W-1:0] rf_code_next;
  reg  [FAULT_W-1:0] fault_next;
  reg                flag_next;

  // negotiation path
  reg                done_reg;
  reg                done_next;
  reg                link_next;
  reg  [SPEED_W-1:0] speed_next;
  reg                duplex_next;
  reg  [PAUSE_W-1:0] pause_next;

  // packed word
  reg  [15:7]        status_next;

  ////////////////////////////////////////////////////////////////////////
  // remote fault capture
  assign rd_status = is_status_read(i_mgmt_rd, i_mgmt_reg); // [RQ6]
  assign rf_event  = fault_taken(i_rf_detect, i_an_enable);  // [RQ5]

  // set wins over a clear in the same cycle, so no fault is lost
  asv_sticky u_flag (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_set     (rf_event),
    .i_clr     (rd_status),
    .o_flag    (rf_flag)
  );

  // keep the type of the last report so the code matches the flag
  always @* begin
    rf_code_next = rf_code_reg;
    if (rf_event) begin
      rf_code_next = i_rf_code; // [RQ2]
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rf_code_reg <= `ASV_RF_NONE;
    end else if (i_ce) begin
      rf_code_reg <= rf_code_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // negotiation done qualifier
  // costs one cycle of latency on the negotiated fields
  always @* begin
    done_next = neg_valid(i_an_enable, i_an_complete);
  end

  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      done_reg <= 1'h0; // [RQ12]
    end else if (i_ce) begin
      done_reg <= done_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next values of the fault fields
  always @* begin
    // the flag passes on in phy mode, where it carries no meaning [RQ7]
    flag_next  = rf_flag; // [RQ5]
    fault_next = fault_view(i_phy_mode, i_an_enable,
                            rf_code_reg); // [RQ2] [RQ3]
  end

  // next values of the link and negotiated fields
  always @* begin
    link_next   = i_phy_link; // [RQ11]
    speed_next  = speed_view(done_reg, i_speed);   // [RQ1] [RQ12]
    duplex_next = done_reg && i_full_duplex;       // [RQ4] [RQ12]
    pause_next  = pause_view(done_reg, i_lp_base); // [RQ8] [RQ9]
  end

  ////////////////////////////////////////////////////////////////////////
  // pack the fields into the word
  always @* begin
    status_next                                  = `ASV_STATUS_RST;
    status_next[`ASV_BIT_LINK]                   = link_next;
    status_next[`ASV_BIT_RF_HI:`ASV_BIT_RF_LO]   = fault_next;
    status_next[`ASV_BIT_SPD_HI:`ASV_BIT_SPD_LO] = speed_next;
    status_next[`ASV_BIT_DUPLEX]                 = duplex_next;
    status_next[`ASV_BIT_RF_FLAG]                = flag_next;
    status_next[`ASV_BIT_PS_HI:`ASV_BIT_PS_LO]   = pause_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // output register, all bits on the core clock [RQ10]
  // a low enable holds the whole word, so no partial update is seen
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_status <= `ASV_STATUS_RST; // [RQ12]
    end else if (i_ce) begin
      o_status <= status_next;
    end
  end

endmodule

/* File: hw/asv_map.vh */
// asv_map.vh: constants for the auto-negotiation status vector block
// assumes inclusion by its bare name from hw/ design files
//
// Contract
// RQ1: speed field 10=1000, 01=100, 00=10 Mb/s, 11 reserved; valid with AN
// RQ2: remote fault encoding on two bits, qualified by the fault flag
// RQ3: in phy mode the fault encoding field reads zero
// RQ4: duplex bit is 1 for full, 0 for half
// RQ5: fault flag goes to 1 when a remote fault is seen; the code sets it only while i_an_enable is high
// RQ6: fault flag sticks until a management read of status register 1
// RQ7: in phy mode the fault flag carries no meaning
// RQ8: partner register 5 bits 8 and 7 go to status bits 15 and 14
// RQ9: pause code 00 none, 01 sym, 10 asym, 11 both
// RQ10: every status output changes only on the core reference clock
// RQ11: status bit 7 shows the far phy link state
// RQ12: reset clears the flag; speed, duplex, pause zero until AN done
`ifndef ASV_MAP_VH
`define ASV_MAP_VH
`define ASV_SPEED_1000  2'h2
`define ASV_SPEED_100   2'h1
`define ASV_SPEED_10    2'h0
`define ASV_RF_NONE     2'h0
`define ASV_PAUSE_HI    8
`define ASV_PAUSE_LO    7
`define ASV_REG_STATUS  5'h01
`define ASV_REG_LP_BASE 5'h05
`define ASV_BIT_LINK    7
`define ASV_BIT_RF_LO   8
`define ASV_BIT_RF_HI   9
`define ASV_BIT_SPD_LO  10
`define ASV_BIT_SPD_HI  11
`define ASV_BIT_DUPLEX  12
`define ASV_BIT_RF_FLAG 13
`define ASV_BIT_PS_LO   14
`define ASV_BIT_PS_HI   15
`define ASV_STATUS_RST  9'h000
`define ASV_FIELD_DELAY 2
`endif

/* File: hw/asv_sticky.v */
// asv_sticky.v: set-dominant sticky flag
// assumes one clock, synchronous active-low reset, clock enable
`timescale 1ns/1ns
module asv_sticky (
  // clock and reset
  input  wire i_sys_clk,
  input  wire i_rstn,
  input  wire i_ce,
  // set and clear
  input  wire i_set,
  input  wire i_clr,
  output reg  o_flag
);
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_flag <= 1'b0; // [RQ12]
    end else if (i_ce) begin
      // set wins so a fault in the clearing cycle is not lost
      if (i_set) begin
        o_flag <= 1'b1; // [RQ5]
      end else if (i_clr) begin
        o_flag <= 1'b0; // [RQ6]
      end
    end
  end
endmodule

/* File: tb/asv_phy_model.sv */
// far phy model: link, partner pause bits, fault reports
// assumes cmd changes just after a clock edge
`timescale 1ns/1ns
module asv_phy_model(input wire clk,input wire [5:0] cmd,output reg link,
output reg rf,output reg [1:0] rc,output reg [15:0] lp);
always @(posedge clk) begin
link<=cmd[5];
lp<={7'h2B,cmd[4:3],7'h54};
rf<=cmd[2];
rc<=cmd[1:0];
end
endmodule

/* File: tb/asv_status_asserts.sv */
// checks on the status outputs
// assumes attempts that overlap a reset or a frozen cycle are dropped
`timescale 1ns/1ns
module asv_status_asserts(input wire i_sys_clk,i_rstn,i_ce,i_an_enable,
i_phy_mode,i_an_complete,i_phy_link,i_full_duplex,i_rf_detect,i_mgmt_rd,
input wire [1:0] i_speed,i_rf_code,input wire [15:0] i_lp_base,
input wire [4:0] i_mgmt_reg,input wire [15:7] o_status);
default clocking @(posedge i_sys_clk);endclocking
default disable iff(!i_rstn||!i_ce);
wire [15:7] s=o_status;
wire r=i_mgmt_rd&&i_mgmt_reg==5'h01,n=i_an_enable&&i_an_complete;
wire q=i_an_enable&&!i_phy_mode,t=i_rf_detect;
wire [4:0] v={i_lp_base[8:7],i_full_duplex,i_speed},o={s[15:14],s[12:10]};
a_link_follow:assert property(1|=>s[7]==$past(i_phy_link))else $error("link");
a_rf_set:assert property(t&&i_an_enable|->##2 s[13])else $error("set");
a_rf_hold:assert property($fell(s[13])|->$past(r,2))else $error("hold");
a_rf_clear:assert property(r&&!t|->##2!s[13])else $error("clr");
a_code_phy:assert property(i_phy_mode[*3]|->s[9:8]==2'h0)else $error("phy");
a_code_value:
assert property(t&&q##1 q##1 q|->s[9:8]==$past(i_rf_code,2))else $error("code");
a_neg_fields:assert property((n&&$stable(v))[*3]|->o==v)else $error("neg");
a_idle_zero:assert property((!n)[*3]|->o==5'h00)else $error("idle");
cover property(r&&s[13]);
cover property(i_phy_mode&&t);
cover property(n&&s[11]);
endmodule
bind asv_status asv_status_asserts asv_status_asserts_inst(.*);

/* File: tb/asv_status_tb_top.sv */
// directed bench for the status word
// assumes the phy model feeds link, partner base and fault
`timescale 1ns/1ns
module asv_status_tb_top;
reg c=0,n=0,e=0,p=0,a=0,d=0,m=0;
reg ce=1;
reg [1:0] s=0;
reg [4:0] g=0;
reg [5:0] k=0;
wire l,f;
wire [1:0] h;
wire [15:0] b;
wire [15:7] o;
integer miscompares=0,samples_checked=0,i;
always #5 c=~c;
asv_phy_model asv_phy_model_inst(.clk(c),.cmd(k),.link(l),.rf(f),.rc(h),.lp(b));
asv_status asv_status_inst(.i_sys_clk(c),.i_rstn(n),.i_ce(ce),.i_an_enable(e),
.i_phy_mode(p),.i_an_complete(a),.i_phy_link(l),.i_speed(s),.i_full_duplex(d),
.i_lp_base(b),.i_rf_detect(f),.i_rf_code(h),.i_mgmt_rd(m),.i_mgmt_reg(g),
.o_status(o));
task w(input integer j);begin repeat(j)@(posedge c);#1;end endtask
task chk(input [8:0] x);begin samples_checked=samples_checked+1;
if(o!==x)begin miscompares=miscompares+1;
$display("Error t=%0t exp=%h got=%h",$time,x,o);end end endtask
task rd(input [4:0] x);begin m=1;g=x;w(1);m=0;w(3);end endtask
task give_verdict;begin
$display("checks %0d mismatches %0d",samples_checked,miscompares);
if(miscompares==0&&samples_checked>0)$display("ALL CHECKS OK");
else $display("CHECKS NOT OK");
$finish;end endtask
initial begin
w(3);chk(9'h000);
n=1;e=1;a=1;s=2'h2;d=1;k=6'h36;w(1);k=6'h32;w(4);
chk(9'h175);
rd(5'h05);chk(9'h175);
rd(5'h01);chk(9'h135);
for(i=0;i<4;i=i+1)begin s=2'(i%3);d=i[0];k={1'b0,i[1:0],3'h2};w(4);
chk({i[1:0],1'b0,i[0],s,3'h4});
end
p=1;w(4);chk(9'h1A0);
a=0;p=0;w(4);chk(9'h004);
e=0;k=6'h06;w(1);k=6'h02;w(4);chk(9'h000);
e=1;k=6'h06;w(1);k=6'h02;m=1;g=5'h01;w(1);m=0;w(3);chk(9'h044);
ce=0;k=6'h20;w(4);chk(9'h044);
m=1;w(1);m=0;w(3);chk(9'h044);
ce=1;w(4);chk(9'h045);
n=0;w(2);chk(9'h000);
n=1;w(4);chk(9'h001);
p=1;k=6'h26;w(1);k=6'h22;w(4);chk(9'h041);
give_verdict;
end
endmodule
